// file: src/scr_regs.v
// spi register bank for sync input and sample clock configuration
`include "scr_defs.vh"
module scr_regs (
  input wire clk,
  input wire rst_b,
  input wire spi_sclk,
  input wire spi_cs_b,
  input wire spi_sdi,
  output reg spi_sdo,
  input wire sync_in,
  input wire [23:0] sync_pos_coarse,
  input wire [23:0] sync_pos_fine,
  output reg sync_align_pulse,
  output wire sync_receiver_enable,
  output wire sync_processor_enable,
  output wire [3:0] sync_delay_select,
  output wire sync_use_calibrated_delay,
  output wire sync_polarity_invert,
  output wire sync_input_pecl_mode,
  output wire sample_clock_pecl_mode,
  output wire [15:0] input_a_full_scale,
  output wire [15:0] input_b_full_scale,
  output wire reference_bypass,
  output wire [1:0] timestamp_input_control
);
  localparam ST_CMD = 1'b0;
  localparam ST_DATA = 1'b1;

  reg [7:0] cfg_r;
  reg [7:0] usr_r;
  reg [7:0] ck0_r;
  reg [7:0] ck1_r;
  reg [15:0] fsa_r;
  reg [15:0] fsb_r;
  reg [7:0] byp_r;
  reg [7:0] tsc_r;

  // two-flop synchronisers, third stage only for edge detection
  reg [1:0] sclk_s_r;
  reg sclk_d_r;
  reg [1:0] cs_s_r;
  reg [1:0] sdi_s_r;
  reg [1:0] syn_s_r;
  reg syn_d_r;
  reg [23:0] posc_s1_r;
  reg [23:0] posc_s2_r;
  reg [23:0] posf_s1_r;
  reg [23:0] posf_s2_r;

  reg state_r;
  reg [3:0] cnt_r;
  reg [15:0] cmd_r;
  reg [7:0] dat_r;
  reg [7:0] out_r;
  reg rd_r;
  reg [14:0] addr_r;

  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire cs_act = ~cs_s_r[1];
  wire [15:0] cmd_full = {cmd_r[14:0], sdi_s_r[1]};
  wire [7:0] dat_full = {dat_r[6:0], sdi_s_r[1]};
  wire [23:0] pos_view = ck0_r[`SCR_B_ZOOM] ? posf_s2_r : posc_s2_r;
  wire syn_eff = syn_s_r[1] ^ ck1_r[`SCR_B_INV];
  wire syn_rise = syn_eff & ~syn_d_r;
  // pulse needs the receiver powered as well as the processor enabled
  wire syn_take = ck0_r[`SCR_B_PROC] & ck0_r[`SCR_B_RECV];
  // writes land on the address of the byte just finished
  wire wr_stb = cs_act & sclk_rise & (state_r == ST_DATA) & (cnt_r == `SCR_BYTE_BITS) & ~rd_r;

  assign sync_receiver_enable = ck0_r[`SCR_B_RECV];
  assign sync_processor_enable = ck0_r[`SCR_B_PROC];
  assign sync_delay_select = ck0_r[`SCR_B_SEL_HI:`SCR_B_SEL_LO];
  assign sync_use_calibrated_delay = (sync_delay_select == 4'h0);
  assign sync_polarity_invert = ck1_r[`SCR_B_INV];
  assign sync_input_pecl_mode = ck1_r[`SCR_B_SYNPECL];
  assign sample_clock_pecl_mode = ck1_r[`SCR_B_CLKPECL];
  assign input_a_full_scale = fsa_r;
  assign input_b_full_scale = fsb_r;
  assign reference_bypass = byp_r[0];
  assign timestamp_input_control = tsc_r[1:0];

  // byte read mux; reserved and unmapped addresses read zero
  function [7:0] rd_byte;
    input [14:0] a;
    begin
      if (a == `SCR_A_CFG) begin
        rd_byte = cfg_r | `SCR_CFG_FOURWIRE;
      end else if (a == `SCR_A_USR) begin
        rd_byte = usr_r;
      end else if (a == `SCR_A_CK0) begin
        rd_byte = ck0_r;
      end else if (a == `SCR_A_CK1) begin
        rd_byte = ck1_r;
      end else if (a == `SCR_A_POS_HI) begin
        rd_byte = pos_view[23:16];
      end else if (a == `SCR_A_POS_MD) begin
        rd_byte = pos_view[15:8];
      end else if (a == `SCR_A_POS_LO) begin
        rd_byte = pos_view[7:0];
      end else if (a == `SCR_A_FSA_HI) begin
        rd_byte = fsa_r[15:8];
      end else if (a == `SCR_A_FSA_LO) begin
        rd_byte = fsa_r[7:0];
      end else if (a == `SCR_A_FSB_HI) begin
        rd_byte = fsb_r[15:8];
      end else if (a == `SCR_A_FSB_LO) begin
        rd_byte = fsb_r[7:0];
      end else if (a == `SCR_A_BYP) begin
        rd_byte = byp_r;
      end else if (a == `SCR_A_TSC) begin
        rd_byte = tsc_r;
      end else begin
        rd_byte = 8'h00;
      end
    end
  endfunction

  // streaming address step
  function [14:0] next_addr;
    input [14:0] a;
    begin
      if (usr_r[`SCR_B_HOLD]) begin
        next_addr = a;
      end else if (cfg_r[`SCR_B_DIR]) begin
        next_addr = a + 15'h0001;
      end else begin
        next_addr = a - 15'h0001;
      end
    end
  endfunction

  // sclk needs a delay stage so both edges are seen
  always @(posedge clk) begin
    if (!rst_b) begin
      sclk_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], spi_sclk};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  // chip select idles high so no frame starts out of reset
  always @(posedge clk) begin
    if (!rst_b) begin
      cs_s_r <= 2'h3;
    end else begin
      cs_s_r <= {cs_s_r[0], spi_cs_b};
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      sdi_s_r <= 2'h0;
    end else begin
      sdi_s_r <= {sdi_s_r[0], spi_sdi};
    end
  end

  // sync pin
  always @(posedge clk) begin
    if (!rst_b) begin
      syn_s_r <= 2'h0;
    end else begin
      syn_s_r <= {syn_s_r[0], sync_in};
    end
  end

  // delay stage holds the previous effective sync level
  always @(posedge clk) begin
    if (!rst_b) begin
      syn_d_r <= 1'b0;
    end else begin
      syn_d_r <= syn_eff;
    end
  end

  // status words change slowly; a torn sample lasts one read only
  always @(posedge clk) begin
    if (!rst_b) begin
      posc_s1_r <= 24'h000000;
      posc_s2_r <= 24'h000000;
    end else begin
      posc_s1_r <= sync_pos_coarse;
      posc_s2_r <= posc_s1_r;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      posf_s1_r <= 24'h000000;
      posf_s2_r <= 24'h000000;
    end else begin
      posf_s1_r <= sync_pos_fine;
      posf_s2_r <= posf_s1_r;
    end
  end

  // alignment pulse on rising edge of the effective sync level
  always @(posedge clk) begin
    if (!rst_b) begin
      sync_align_pulse <= 1'b0;
    end else begin
      sync_align_pulse <= syn_rise & syn_take;
    end
  end

  // register file; each reset value sits beside its write
  always @(posedge clk) begin
    if (!rst_b) begin
      cfg_r <= `SCR_RST_CFG;
    end else if (wr_stb && addr_r == `SCR_A_CFG) begin
      cfg_r <= dat_full & `SCR_CFG_WMASK;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      usr_r <= `SCR_RST_USR;
    end else if (wr_stb && addr_r == `SCR_A_USR) begin
      usr_r <= dat_full;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      ck0_r <= `SCR_RST_CK0;
    end else if (wr_stb && addr_r == `SCR_A_CK0) begin
      ck0_r <= dat_full;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      ck1_r <= `SCR_RST_CK1;
    end else if (wr_stb && addr_r == `SCR_A_CK1) begin
      ck1_r <= dat_full;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      fsa_r <= `SCR_RST_FS;
    end else if (wr_stb && addr_r == `SCR_A_FSA_HI) begin
      fsa_r[15:8] <= dat_full;
    end else if (wr_stb && addr_r == `SCR_A_FSA_LO) begin
      fsa_r[7:0] <= dat_full;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      fsb_r <= `SCR_RST_FS;
    end else if (wr_stb && addr_r == `SCR_A_FSB_HI) begin
      fsb_r[15:8] <= dat_full;
    end else if (wr_stb && addr_r == `SCR_A_FSB_LO) begin
      fsb_r[7:0] <= dat_full;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      byp_r <= `SCR_RST_BYP;
    end else if (wr_stb && addr_r == `SCR_A_BYP) begin
      byp_r <= dat_full;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      tsc_r <= `SCR_RST_TSC;
    end else if (wr_stb && addr_r == `SCR_A_TSC) begin
      tsc_r <= dat_full;
    end
  end

  // spi frame engine; cs high aborts a frame and drops a partial byte
  always @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_CMD;
      cnt_r <= 4'h0;
      cmd_r <= 16'h0000;
      dat_r <= 8'h00;
      out_r <= 8'h00;
      rd_r <= 1'b0;
      addr_r <= 15'h0000;
      spi_sdo <= 1'b0;
    end else if (!cs_act) begin
      state_r <= ST_CMD;
      cnt_r <= 4'h0;
    end else if (sclk_fall) begin
      spi_sdo <= out_r[7];
      out_r <= {out_r[6:0], 1'b0};
    end else if (sclk_rise) begin
      case (state_r)
        ST_CMD: begin
          cmd_r <= cmd_full;
          if (cnt_r == `SCR_CMD_BITS) begin
            state_r <= ST_DATA;
            cnt_r <= 4'h0;
            rd_r <= cmd_full[15];
            addr_r <= cmd_full[14:0];
            out_r <= rd_byte(cmd_full[14:0]);
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          dat_r <= dat_full;
          if (cnt_r == `SCR_BYTE_BITS) begin
            cnt_r <= 4'h0;
            addr_r <= next_addr(addr_r);
            out_r <= rd_byte(next_addr(addr_r));
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
      endcase
    end
  end
endmodule

// file: src/scr_defs.vh
// address map, reset values and field positions of the clock configuration bank
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH
`define SCR_AW 15
`define SCR_A_CFG 15'h0000
`define SCR_A_USR 15'h0010
`define SCR_A_CK0 15'h0029
`define SCR_A_CK1 15'h002a
`define SCR_A_POS_HI 15'h002c
`define SCR_A_POS_MD 15'h002d
`define SCR_A_POS_LO 15'h002e
`define SCR_A_FSA_HI 15'h0030
`define SCR_A_FSA_LO 15'h0031
`define SCR_A_FSB_HI 15'h0032
`define SCR_A_FSB_LO 15'h0033
`define SCR_A_BYP 15'h0038
`define SCR_A_TSC 15'h003b
`define SCR_RST_CFG 8'h20
`define SCR_RST_USR 8'h00
`define SCR_RST_CK0 8'h00
`define SCR_RST_CK1 8'h20
`define SCR_RST_FS 16'ha000
`define SCR_RST_BYP 8'h00
`define SCR_RST_TSC 8'h00
`define SCR_CFG_WMASK 8'h20
`define SCR_CFG_FOURWIRE 8'h10
`define SCR_B_DIR 5
`define SCR_B_HOLD 0
`define SCR_B_PROC 6
`define SCR_B_RECV 5
`define SCR_B_ZOOM 4
`define SCR_B_SEL_HI 3
`define SCR_B_SEL_LO 0
`define SCR_B_CLKPECL 2
`define SCR_B_SYNPECL 1
`define SCR_B_INV 0
`define SCR_CMD_BITS 4'hf
`define SCR_BYTE_BITS 4'h7
`endif

// file: test/scr_regs_properties.sv
// concurrent checks on the clock configuration register bank ports
module scr_regs_properties (
  input wire clk,
  input wire rst_b,
  input wire spi_cs_b,
  input wire sync_in,
  input wire sync_align_pulse,
  input wire sync_receiver_enable,
  input wire sync_processor_enable,
  input wire [3:0] sync_delay_select,
  input wire sync_use_calibrated_delay,
  input wire sync_polarity_invert,
  input wire sync_input_pecl_mode,
  input wire sample_clock_pecl_mode,
  input wire [15:0] input_a_full_scale,
  input wire [15:0] input_b_full_scale
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_pulse_needs_en: assert property (sync_align_pulse |-> sync_processor_enable && sync_receiver_enable)
    else $error("align pulse without both enables");
  a_pulse_one_cycle: assert property (sync_align_pulse |=> !sync_align_pulse)
    else $error("align pulse longer than one cycle");
  a_calib_flag: assert property (sync_use_calibrated_delay == (sync_delay_select == 4'h0))
    else $error("calibrated delay flag wrong");
  a_quiet_no_pulse: assert property (($stable(sync_in) && $stable(sync_polarity_invert))[*6] |-> !sync_align_pulse)
    else $error("align pulse without sync edge");
  a_scale_idle_hold: assert property (spi_cs_b[*8] |-> $stable({input_a_full_scale, input_b_full_scale}))
    else $error("full scale changed outside a frame");
  a_ctl_idle_hold: assert property (spi_cs_b[*8] |-> $stable({sync_receiver_enable, sync_processor_enable}))
    else $error("enables changed outside a frame");
  a_mode_idle_hold: assert property (spi_cs_b[*8] |-> $stable({sync_input_pecl_mode, sample_clock_pecl_mode}))
    else $error("pecl modes changed outside a frame");
  a_reset_values: assert property ($rose(rst_b) |-> input_a_full_scale == 16'ha000 && !sync_processor_enable
    && !sync_receiver_enable && sync_delay_select == 4'h0 && !sample_clock_pecl_mode && !sync_input_pecl_mode)
    else $error("wrong value after reset");
endmodule
bind scr_regs scr_regs_properties scr_regs_properties_i (.clk(clk), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
  .sync_in(sync_in), .sync_align_pulse(sync_align_pulse), .sync_receiver_enable(sync_receiver_enable),
  .sync_processor_enable(sync_processor_enable), .sync_delay_select(sync_delay_select),
  .sync_use_calibrated_delay(sync_use_calibrated_delay), .sync_polarity_invert(sync_polarity_invert),
  .sync_input_pecl_mode(sync_input_pecl_mode), .sample_clock_pecl_mode(sample_clock_pecl_mode),
  .input_a_full_scale(input_a_full_scale), .input_b_full_scale(input_b_full_scale));

// file: test/scr_host.sv
// spi host model driving four-wire frames into the register bank
module scr_host (
  input wire clk,
  output logic spi_sclk,
  output logic spi_cs_b,
  output logic spi_sdi,
  input wire spi_sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_sclk = 0;
    spi_cs_b = 1;
    spi_sdi = 0;
  end
  // five clocks per sclk phase, reply sampled on the rising sclk
  task automatic bitx(input logic b, output logic r);
    spi_sdi = b;
    repeat (5) @(negedge clk);
    spi_sclk = 1;
    r = spi_sdo;
    repeat (5) @(negedge clk);
    spi_sclk = 0;
  endtask
  task automatic frame(input logic [15:0] cmd, input int n, inout logic [7:0] d [4]);
    logic r;
    logic [7:0] q;
    @(negedge clk);
    spi_cs_b = 0;
    for (int i = 15; i >= 0; i--) bitx(cmd[i], r);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bitx(d[k][i], r);
        q[i] = r;
      end
      if (cmd[15]) d[k] = q;
    end
    repeat (5) @(negedge clk);
    spi_cs_b = 1;
    // released data line does not keep its last level
    spi_sdi = ~spi_sdi;
    repeat (6) @(negedge clk);
  endtask
endmodule

// file: test/tb_scr_regs.sv
// self-checking bench for the clock configuration register bank
module tb_scr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [14:0] a; logic [7:0] w; logic [7:0] r;} scr_row_t;
  logic clk, rst_b, spi_sclk, spi_cs_b, spi_sdi, spi_sdo, sync_in, sync_align_pulse;
  logic sync_receiver_enable, sync_processor_enable, sync_use_calibrated_delay, sync_polarity_invert;
  logic sync_input_pecl_mode, sample_clock_pecl_mode, reference_bypass;
  logic [23:0] sync_pos_coarse, sync_pos_fine;
  logic [3:0] sync_delay_select;
  logic [15:0] input_a_full_scale, input_b_full_scale;
  logic [1:0] timestamp_input_control;
  logic [7:0] d [4];
  int num_errors = 0;
  int checked = 0;
  int pulse_cnt = 0;
  scr_row_t rows [8] = '{'{15'h000, 8'hff, 8'h30}, '{15'h029, 8'h20, 8'h20}, '{15'h029, 8'h6f, 8'h6f},
    '{15'h02a, 8'h26, 8'h26},
    '{15'h038, 8'hfe, 8'hfe}, '{15'h020, 8'hff, 8'h00}, '{15'h047, 8'ha5, 8'h00}, '{15'h03b, 8'h03, 8'h03}};
  scr_regs scr_regs_i (.*);
  scr_host scr_host_i (.*);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) pulse_cnt <= pulse_cnt + int'(sync_align_pulse);
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [14:0] a, input logic [7:0] b);
    d[0] = b;
    scr_host_i.frame({1'b0, a}, 1, d);
  endtask
  task rd(input logic [14:0] a, input int n);
    scr_host_i.frame({1'b1, a}, n, d);
  endtask
  task pulse(input int e);
    int base;
    base = pulse_cnt;
    sync_in = 1;
    repeat (8) @(negedge clk);
    chk("pulses", pulse_cnt - base, e);
    sync_in = 0;
    repeat (8) @(negedge clk);
  endtask
  task complete_run;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    complete_run;
  end
  initial begin
    rst_b = 0;
    sync_in = 0;
    sync_pos_coarse = 24'h123456;
    sync_pos_fine = 24'habcdef;
    repeat (10) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    rd(15'h02a, 1);
    chk("ctl1", d[0], 8'h20);
    rd(15'h030, 2);
    chk("scale_a", {d[0], d[1]}, 16'ha000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, 1);
      chk("row", d[0], rows[i].r);
    end
    chk("ctl_pins", {sync_receiver_enable, sync_processor_enable, sync_delay_select, sync_use_calibrated_delay,
      sample_clock_pecl_mode, sync_input_pecl_mode, sync_polarity_invert, reference_bypass,
      timestamp_input_control}, 13'h1fb3);
    d = '{8'h20, 8'h00, 8'h00, 8'h00};
    scr_host_i.frame(16'h0030, 2, d);
    chk("scale_a", input_a_full_scale, 16'h2000);
    wr(15'h000, 8'h00);
    d = '{8'h12, 8'h34, 8'h00, 8'h00};
    scr_host_i.frame(16'h0033, 2, d);
    chk("scale_b", input_b_full_scale, 16'h3412);
    wr(15'h010, 8'h01);
    d = '{8'h11, 8'h22, 8'h00, 8'h00};
    scr_host_i.frame(16'h0031, 2, d);
    chk("scales", {input_a_full_scale, input_b_full_scale}, 32'h20223412);
    wr(15'h010, 8'h00);
    wr(15'h000, 8'h20);
    wr(15'h029, 8'h20);
    chk("calibrated", sync_use_calibrated_delay, 1'b1);
    rd(15'h02c, 3);
    chk("position", {d[0], d[1], d[2]}, 24'h123456);
    wr(15'h029, 8'h30);
    rd(15'h02c, 3);
    chk("fine_position", {d[0], d[1], d[2]}, 24'habcdef);
    wr(15'h029, 8'h20 | (d[2] & 8'h0f));
    pulse(0);
    wr(15'h029, 8'h6f);
    pulse(1);
    wr(15'h02a, 8'h27);
    chk("invert", sync_polarity_invert, 1'b1);
    pulse(0);
    rst_b = 0;
    repeat (2) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    chk("after_reset", {input_a_full_scale, sync_processor_enable, sync_polarity_invert}, 18'h28000);
    complete_run;
  end
endmodule
